// File: design/trp_timer.sv
`timescale 1ns/10ps
`include "trp_params.svh"

// Behaviour
// - overflow reloads counter from reload register automatically
// - reload write staged, made active at overflow
// - reload register 8-bit write-only, resets zero
// - duty register 8-bit read/write, sets high time
// - pwm goes low when counter equals duty
// - external select counts falling edges of event pin
// - event mode wrap FF to 00 overflows too
// - event counting blocks event pin wake-up
// - event counting disables pin interrupt, flag zero
// - pwm on pin only when running and enabled
// - each pwm cycle with duty above reload starts high then low
// - counter loaded from reload on timer enable
// - overflow ends cycle, drives pwm high again
// - duty not above reload keeps pwm low
// - reload value sets pwm resolution steps
// - pwm overflow still sets flag and interrupt
// - pwm enable switches shared pin to/from gpio
// - FF to 00 sets sticky overflow flag
// - timer counts only while run bit set
// - clock-source bits pick pin, cpu or oscillator
// - rate code 000 divides 128, 111 divides 1
module trp_timer #(
  parameter int DATA_W = 8,
  parameter int ADDR_W = 8
) (
  input  wire logic                   clk_i,
  input  wire logic                   nrst_i,
  // register port
  input  wire logic [ADDR_W-1:0]      addr_i,
  input  wire logic [DATA_W-1:0]      wdata_i,
  input  wire logic                   wr_i,
  input  wire logic                   rd_i,
  output logic      [DATA_W-1:0]      rdata_o,
  // high-speed oscillator rate as a one-cycle enable
  input  wire logic                   hosc_en_i,
  // asynchronous event input pin
  input  wire logic                   event_pin_i,
  // raw external interrupt request of the event pin
  input  wire logic                   event_int_req_i,
  // general-purpose drive of the shared pwm pin
  input  wire logic                   gpio_out_i,
  input  wire logic                   gpio_oe_i,
  // shared pwm pin
  output logic                        pwm_pin_o,
  output logic                        pwm_pin_oe_o,
  // status towards the core
  output logic                        overflow_o,
  output logic                        overflow_irq_o,
  output logic                        event_int_req_o,
  output logic                        event_wake_block_o,
  output trp_pkg::trp_clk_src_type    clk_src_o
);

  import trp_pkg::*;

  // software-visible registers
  logic [DATA_W-1:0]               mode_reg;
  logic [DATA_W-1:0]               count_reg;
  logic [DATA_W-1:0]               reload_stage_reg;
  logic [DATA_W-1:0]               reload_active_reg;
  logic [DATA_W-1:0]               duty_reg;
  logic                            ovf_flag_reg;
  logic                            evf_flag_reg;
  logic                            ien_reg;
  logic [DATA_W-1:0]               rdata_reg;
  // internal state
  logic [`TRP_PRESCALE_W-1:0]      pre_reg;
  logic                            pwm_reg;
  logic                            run_last_reg;

  // decoded mode fields
  logic                            timer_run_enable;
  logic [2:0]                      prescale_rate_field;
  logic                            external_clock_select;
  logic                            oscillator_clock_select;
  logic                            pwm_pin_enable;
  trp_clk_src_type                 src_sel;

  // address decode
  logic                            hit_mode;
  logic                            hit_count;
  logic                            hit_reload;
  logic                            hit_duty;
  logic                            hit_status;
  logic                            wr_mode;
  logic                            wr_count;
  logic                            wr_reload;
  logic                            wr_duty;
  logic                            wr_status;

  // timing terms
  logic                            src_en;
  logic [`TRP_PRESCALE_W-1:0]      pre_mask;
  logic                            pre_tick;
  logic                            event_fall;
  logic                            timer_tick;
  logic                            run_start;
  logic                            ovf_event;
  logic [DATA_W-1:0]               count_inc;
  logic [DATA_W-1:0]               count_next;
  logic [DATA_W-1:0]               reload_active_next;
  logic                            pwm_next;
  logic [DATA_W-1:0]               rdata_next;
  logic                            evf_set;

  // mode register fields
  assign timer_run_enable        = mode_reg[`TRP_MODE_RUN_BIT];
  assign prescale_rate_field     = mode_reg[`TRP_MODE_RATE_HI:`TRP_MODE_RATE_LO];
  assign external_clock_select   = mode_reg[`TRP_MODE_EXT_BIT];
  assign oscillator_clock_select = mode_reg[`TRP_MODE_OSC_BIT];
  assign pwm_pin_enable          = mode_reg[`TRP_MODE_PWM_BIT];

  assign src_sel = external_clock_select ? TRP_SRC_EXT :
                   oscillator_clock_select ? TRP_SRC_HOSC : TRP_SRC_CPU;
  assign clk_src_o = src_sel;

  // address decode for the plain register port
  assign hit_mode   = (addr_i == `TRP_MODE_ADDR);
  assign hit_count  = (addr_i == `TRP_COUNT_ADDR);
  assign hit_reload = (addr_i == `TRP_RELOAD_ADDR);
  assign hit_duty   = (addr_i == `TRP_DUTY_ADDR);
  assign hit_status = (addr_i == `TRP_STATUS_ADDR);
  assign wr_mode    = wr_i & hit_mode;
  assign wr_count   = wr_i & hit_count;
  assign wr_reload  = wr_i & hit_reload;
  assign wr_duty    = wr_i & hit_duty;
  assign wr_status  = wr_i & hit_status;

  trp_edge_sync u_event_sync (
    .clk_i   (clk_i),
    .nrst_i  (nrst_i),
    .async_i (event_pin_i),
    .fall_o  (event_fall)
  );

  // prescaler advances on the internal source rate only
  assign src_en = (src_sel == TRP_SRC_HOSC) ? hosc_en_i : 1'b1;

  // divisor 128 >> rate, tick when masked bits all ones
  assign pre_mask = `TRP_PRESCALE_MAX >> prescale_rate_field;
  assign pre_tick = src_en & ((pre_reg & pre_mask) == pre_mask);

  // falling edges clock the counter in event mode
  assign timer_tick = timer_run_enable &
                      ((src_sel == TRP_SRC_EXT) ? event_fall : pre_tick);

  // a 0 to 1 on the run bit restarts the interval
  assign run_start = timer_run_enable & ~run_last_reg;

  // wrap from all ones is the overflow, same in both modes
  // event ticks wrap the same way
  assign count_inc = count_reg + 8'h01;
  assign ovf_event = timer_tick & (count_reg == 8'hFF);

  // staged reload becomes active at overflow or on start
  assign reload_active_next = (ovf_event | run_start) ? reload_stage_reg : reload_active_reg;

  // counter next value; a software write loses to run start, overflow and any timer tick
  always_comb begin
    count_next = count_reg;
    if (run_start) begin
      count_next = reload_active_next;
    end else if (ovf_event) begin
      count_next = reload_active_next;
    end else if (timer_tick) begin
      count_next = count_inc;
    end else if (wr_count) begin
      count_next = wdata_i;
    end
  end

  // pwm level, updated on timer ticks, on run start and forced low while stopped
  always_comb begin
    pwm_next = pwm_reg;
    if (!timer_run_enable) begin
      pwm_next = 1'b0;
    end else if (run_start | ovf_event) begin
      // overflow starts the next high phase
      // duty not above reload never goes high
      pwm_next = (duty_reg > reload_active_next);
    end else if (timer_tick && (count_inc == duty_reg)) begin
      // compared on the timer tick only
      pwm_next = 1'b0;
    end
  end

  // pin interrupt flag held at zero while counting events
  assign evf_set = event_int_req_i & ~external_clock_select;

  // read mux; the reload register is write-only and reads zero
  always_comb begin
    rdata_next = '0;
    if (hit_mode) begin
      rdata_next = mode_reg & 8'hFD;
    end else if (hit_count) begin
      rdata_next = count_reg;
    end else if (hit_duty) begin
      rdata_next = duty_reg;
    end else if (hit_status) begin
      rdata_next[`TRP_STAT_OVF_BIT] = ovf_flag_reg;
      rdata_next[`TRP_STAT_EVF_BIT] = evf_flag_reg;
      rdata_next[`TRP_STAT_IEN_BIT] = ien_reg;
    end
  end

  // mode, duty, reload staging
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      mode_reg         <= `TRP_MODE_RST;
      duty_reg         <= `TRP_DUTY_RST;
      reload_stage_reg <= `TRP_RELOAD_RST;
    end else begin
      if (wr_mode) begin
        mode_reg <= wdata_i;
      end
      if (wr_duty) begin
        duty_reg <= wdata_i;
      end
      // write lands in the staging buffer
      if (wr_reload) begin
        reload_stage_reg <= wdata_i;
      end
    end
  end

  // counting state
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      count_reg         <= `TRP_COUNT_RST;
      reload_active_reg <= `TRP_RELOAD_RST;
      pre_reg           <= '0;
      run_last_reg      <= 1'b0;
    end else begin
      count_reg         <= count_next;
      reload_active_reg <= reload_active_next;
      run_last_reg      <= timer_run_enable;
      // prescaler free-runs on its source so rate changes take effect quickly
      if (src_en) begin
        pre_reg <= pre_reg + 7'h01;
      end
    end
  end

  // registered pwm avoids glitches on the pin
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      pwm_reg <= 1'b0;
    end else begin
      pwm_reg <= pwm_next;
    end
  end

  // sticky flags: a set in the clearing cycle wins
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      ovf_flag_reg <= 1'b0;
      evf_flag_reg <= 1'b0;
      ien_reg      <= 1'b0;
    end else begin
      // set by overflow, cleared by writing zero
      // also set while the pwm runs
      if (ovf_event) begin
        ovf_flag_reg <= 1'b1;
      end else if (wr_status && !wdata_i[`TRP_STAT_OVF_BIT]) begin
        ovf_flag_reg <= 1'b0;
      end
      if (external_clock_select) begin
        evf_flag_reg <= 1'b0;
      end else if (evf_set) begin
        evf_flag_reg <= 1'b1;
      end else if (wr_status && !wdata_i[`TRP_STAT_EVF_BIT]) begin
        evf_flag_reg <= 1'b0;
      end
      if (wr_status) begin
        ien_reg <= wdata_i[`TRP_STAT_IEN_BIT];
      end
    end
  end

  // read data stands in the cycle after the strobe only
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rdata_reg <= '0;
    end else if (rd_i) begin
      rdata_reg <= rdata_next;
    end else begin
      rdata_reg <= '0;
    end
  end

  assign rdata_o = rdata_reg;
  // interrupt request when enabled and flagged
  assign overflow_o     = ovf_flag_reg;
  assign overflow_irq_o = ovf_flag_reg & ien_reg;

  assign event_wake_block_o = external_clock_select;
  // external interrupt masked in event mode
  assign event_int_req_o    = evf_flag_reg;

  // waveform only while running; pwm_reg is low when stopped
  // pin mux follows the enable bit, no run bit change needed
  assign pwm_pin_o    = pwm_pin_enable ? pwm_reg : gpio_out_i;
  assign pwm_pin_oe_o = pwm_pin_enable ? 1'b1 : gpio_oe_i;

endmodule

// File: pkg/trp_params.svh
`ifndef TRP_PARAMS_SVH
`define TRP_PARAMS_SVH

// register offsets on the plain register port
`define TRP_MODE_ADDR      8'hB8
`define TRP_COUNT_ADDR     8'hB9
`define TRP_RELOAD_ADDR    8'hBA
`define TRP_DUTY_ADDR      8'hBB
`define TRP_STATUS_ADDR    8'hBE

// mode register field positions
`define TRP_MODE_RUN_BIT   7
`define TRP_MODE_RATE_HI   6
`define TRP_MODE_RATE_LO   4
`define TRP_MODE_EXT_BIT   3
`define TRP_MODE_OSC_BIT   2
`define TRP_MODE_PWM_BIT   0

// status register field positions
`define TRP_STAT_OVF_BIT   0
`define TRP_STAT_EVF_BIT   1
`define TRP_STAT_IEN_BIT   2

// reset values
`define TRP_MODE_RST       8'h00
`define TRP_COUNT_RST      8'h00
`define TRP_RELOAD_RST     8'h00
`define TRP_DUTY_RST       8'h00

// prescaler: divide-by-128 at rate code 000
`define TRP_PRESCALE_W     7
`define TRP_PRESCALE_MAX   7'h7F

`endif

// File: pkg/trp_pkg.sv
package trp_pkg;

  // timer clock source currently selected
  typedef enum logic [1:0] {
    TRP_SRC_CPU,
    TRP_SRC_HOSC,
    TRP_SRC_EXT
  } trp_clk_src_type;

endpackage

// File: design/trp_edge_sync.sv
`timescale 1ns/10ps

module trp_edge_sync (
  input  wire logic clk_i,
  input  wire logic nrst_i,
  input  wire logic async_i,
  output logic      fall_o
);

  logic meta_reg;
  logic sync_reg;
  logic last_reg;

  // two-flop synchroniser; the edge detector compares sync_reg with last_reg
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      meta_reg <= 1'b1;
      sync_reg <= 1'b1;
      last_reg <= 1'b1;
    end else begin
      meta_reg <= async_i;
      sync_reg <= meta_reg;
      last_reg <= sync_reg;
    end
  end

  // one-cycle pulse per falling edge, so each edge counts exactly once
  assign fall_o = last_reg & ~sync_reg;

endmodule

// File: testbench/trp_timer_monitor.sv
`timescale 1ns/10ps
`include "trp_params.svh"

module trp_timer_monitor #(
  parameter int DATA_W = 8,
  parameter int ADDR_W = 8
) (
  input wire logic                     clk_i,
  input wire logic                     nrst_i,
  input wire logic [ADDR_W-1:0]        addr_i,
  input wire logic [DATA_W-1:0]        wdata_i,
  input wire logic                     wr_i,
  input wire logic                     rd_i,
  input wire logic [DATA_W-1:0]        rdata_o,
  input wire logic                     gpio_out_i,
  input wire logic                     gpio_oe_i,
  input wire logic                     pwm_pin_o,
  input wire logic                     pwm_pin_oe_o,
  input wire logic                     overflow_o,
  input wire logic                     overflow_irq_o,
  input wire logic                     event_int_req_o,
  input wire logic                     event_wake_block_o,
  input wire trp_pkg::trp_clk_src_type clk_src_o
);
  import trp_pkg::*;
  logic [7:0] mode_reg;
  logic [7:0] duty_reg;
  logic [7:0] rel_reg;
  logic       ien_reg;
  // shadow copies of the software-visible settings
  wire wr_mode = wr_i && addr_i == `TRP_MODE_ADDR;
  wire clr_ovf = wr_i && addr_i == `TRP_STATUS_ADDR && !wdata_i[0];
  wire pen     = mode_reg[0];
  wire run     = mode_reg[7];
  wire ext     = mode_reg[3];
  wire hi_exp  = duty_reg > rel_reg;
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      mode_reg <= 8'h00;
      duty_reg <= 8'h00;
      rel_reg  <= 8'h00;
      ien_reg  <= 1'b0;
    end else begin
      if (wr_mode) mode_reg <= wdata_i;
      if (wr_i && addr_i == `TRP_DUTY_ADDR) duty_reg <= wdata_i;
      if (wr_i && addr_i == `TRP_RELOAD_ADDR) rel_reg <= wdata_i;
      if (wr_i && addr_i == `TRP_STATUS_ADDR) ien_reg <= wdata_i[2];
    end
  end

  default clocking @(posedge clk_i); endclocking
  default disable iff (!nrst_i);
  // a run start and an overflow both open a pwm cycle
  sequence start_s;
    wr_mode && wdata_i[7] && wdata_i[0] && !run;
  endsequence
  sequence ovf_s;
    $rose(overflow_o) && pen && run;
  endsequence

  pwm_start_a: assert property (start_s |-> ##2 pwm_pin_o == hi_exp)
    else $error("pwm level wrong after start");
  pwm_ovf_a: assert property (ovf_s |-> pwm_pin_o == hi_exp)
    else $error("pwm level wrong after overflow");
  stop_low_a: assert property (pen && !run && !$past(run) |-> !pwm_pin_o)
    else $error("pwm high while stopped");
  pin_oe_a: assert property (pen |-> pwm_pin_oe_o)
    else $error("pwm pin not driven");
  gpio_mux_a: assert property (!pen |-> pwm_pin_o == gpio_out_i && pwm_pin_oe_o == gpio_oe_i)
    else $error("pin not back to gpio");
  wake_block_a: assert property (event_wake_block_o == ext)
    else $error("wake block wrong");
  pin_flag_a: assert property (ext && $past(ext) |-> !event_int_req_o)
    else $error("pin flag set in event mode");
  src_sel_a: assert property (clk_src_o == (ext ? TRP_SRC_EXT : mode_reg[2] ? TRP_SRC_HOSC : TRP_SRC_CPU))
    else $error("clock source wrong");
  irq_out_a: assert property (overflow_irq_o == (overflow_o && ien_reg))
    else $error("irq level wrong");
  ovf_hold_a: assert property (overflow_o && !clr_ovf |=> overflow_o)
    else $error("overflow flag lost");
  reload_wo_a: assert property (rd_i && addr_i == `TRP_RELOAD_ADDR |=> rdata_o == 8'h00)
    else $error("reload readable");
  duty_rw_a: assert property (rd_i && addr_i == `TRP_DUTY_ADDR |=> rdata_o == duty_reg)
    else $error("duty readback wrong");
endmodule

bind trp_timer trp_timer_monitor #(.DATA_W(DATA_W), .ADDR_W(ADDR_W)) i_mon (
  .clk_i(clk_i), .nrst_i(nrst_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
  .rdata_o(rdata_o), .gpio_out_i(gpio_out_i), .gpio_oe_i(gpio_oe_i), .pwm_pin_o(pwm_pin_o),
  .pwm_pin_oe_o(pwm_pin_oe_o), .overflow_o(overflow_o), .overflow_irq_o(overflow_irq_o),
  .event_int_req_o(event_int_req_o), .event_wake_block_o(event_wake_block_o), .clk_src_o(clk_src_o)
);

// File: testbench/trp_far_end.sv
`timescale 1ns/10ps

module trp_far_end (
  input  wire logic        clk_i,
  input  wire logic        pulse_i,
  input  wire logic        clr_i,
  input  wire logic        pwm_pin_i,
  input  wire logic        pwm_oe_i,
  output logic             event_pin_o,
  output logic [15:0]      high_cnt_o
);
  logic [2:0] low_reg = 3'h0;
  // pulled-up event line, held low 6 clocks per request
  always_ff @(posedge clk_i) begin
    if (pulse_i) low_reg <= 3'h6;
    else if (low_reg != 3'h0) low_reg <= low_reg - 3'h1;
  end
  assign event_pin_o = (low_reg == 3'h0);
  // load counts driven-high cycles; undriven line is not counted
  always_ff @(posedge clk_i) begin
    if (clr_i) high_cnt_o <= 16'h0000;
    else if (pwm_oe_i && pwm_pin_i) high_cnt_o <= high_cnt_o + 16'h0001;
  end
endmodule

// File: testbench/trp_timer_tb.sv
`timescale 1ns/10ps
`include "trp_params.svh"

module trp_timer_tb;
  import trp_pkg::*;
  logic            clk_i = 1'b0;
  logic            nrst_i = 1'b0;
  logic [7:0]      addr_i = 8'h00;
  logic [7:0]      wdata_i = 8'h00;
  logic            wr_i = 1'b0;
  logic            rd_i = 1'b0;
  logic            ev_req = 1'b0;
  logic            pulse = 1'b0;
  logic            clr = 1'b0;
  logic [7:0]      cyc = 8'h00;
  logic            gpio_out_i = 1'b0;
  logic            gpio_oe_i = 1'b0;
  logic            hosc_en_i = 1'b0;
  logic [7:0]      rdata_o;
  logic            ev_pin;
  logic            pwm_pin_o;
  logic            pwm_pin_oe_o;
  logic            overflow_o;
  logic            overflow_irq_o;
  logic            ev_flag;
  logic            wake_blk;
  trp_clk_src_type clk_src_o;
  logic [15:0]     high_cnt;
  int              n;
  int              n_fail = 0;
  int              tests_run = 0;

  trp_timer i_dut (
    .clk_i(clk_i), .nrst_i(nrst_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
    .rdata_o(rdata_o), .hosc_en_i(hosc_en_i), .event_pin_i(ev_pin), .event_int_req_i(ev_req),
    .gpio_out_i(gpio_out_i), .gpio_oe_i(gpio_oe_i), .pwm_pin_o(pwm_pin_o), .pwm_pin_oe_o(pwm_pin_oe_o),
    .overflow_o(overflow_o), .overflow_irq_o(overflow_irq_o), .event_int_req_o(ev_flag),
    .event_wake_block_o(wake_blk), .clk_src_o(clk_src_o)
  );
  trp_far_end i_far (
    .clk_i(clk_i), .pulse_i(pulse), .clr_i(clr), .pwm_pin_i(pwm_pin_o), .pwm_oe_i(pwm_pin_oe_o),
    .event_pin_o(ev_pin), .high_cnt_o(high_cnt)
  );

  initial begin
    forever #25 clk_i = ~clk_i;
  end
  // moving gpio drive so the pin mux is really exercised
  always @(posedge clk_i) begin
    cyc <= cyc + 8'h01;
    gpio_out_i <= cyc[0];
    gpio_oe_i <= cyc[1];
    hosc_en_i <= (cyc[1:0] == 2'h3);
  end

  task automatic conclude;
    $display("checks=%0d errors=%0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_fail++;
      $display("Error t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge clk_i);
    addr_i <= a;
    wdata_i <= v;
    wr_i <= 1'b1;
    @(posedge clk_i);
    wr_i <= 1'b0;
    #1;
  endtask
  // read data stand only in the cycle after the strobe
  task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1 chk(rdata_o, exp);
  endtask
  task automatic wait_ovf;
    n = 0;
    while (overflow_o !== 1'b1 && n < 400) begin
      @(posedge clk_i);
      #1 n++;
    end
  endtask
  // high cycles seen by the load over 20 clocks
  task automatic pwm_hi(input logic [7:0] exp);
    @(posedge clk_i);
    clr <= 1'b1;
    @(posedge clk_i);
    clr <= 1'b0;
    repeat (20) @(posedge clk_i);
    #1 chk(high_cnt[7:0], exp);
  endtask
  task automatic ev_pulse;
    @(posedge clk_i);
    pulse <= 1'b1;
    @(posedge clk_i);
    pulse <= 1'b0;
    repeat (14) @(posedge clk_i);
    #1;
  endtask
  task automatic irq_pulse(input logic [7:0] exp);
    @(posedge clk_i);
    ev_req <= 1'b1;
    @(posedge clk_i);
    ev_req <= 1'b0;
    #1 chk(8'(ev_flag), exp);
  endtask

  initial begin
    #(50 * 4000);
    n_fail++;
    conclude();
  end

  initial begin
    repeat (3) @(posedge clk_i);
    nrst_i <= 1'b1;
    rchk(`TRP_MODE_ADDR, 8'h00);
    rchk(`TRP_RELOAD_ADDR, 8'h00);
    rchk(`TRP_DUTY_ADDR, 8'h00);
    wr(`TRP_DUTY_ADDR, 8'hA5);
    rchk(`TRP_DUTY_ADDR, 8'hA5);
    wr(`TRP_RELOAD_ADDR, 8'h3C);
    rchk(`TRP_RELOAD_ADDR, 8'h00);
    wr(8'h55, 8'h77);
    rchk(8'h55, 8'h00);
    for (int i = 0; i < 4; i++) begin
      wr(`TRP_MODE_ADDR, 8'(i * 4));
      chk(8'(clk_src_o), 8'(i > 1 ? TRP_SRC_EXT : i == 1 ? TRP_SRC_HOSC : TRP_SRC_CPU));
      chk(8'(wake_blk), 8'(i >> 1));
    end
    // two-step pwm cycle at full tick rate
    wr(`TRP_MODE_ADDR, 8'h00);
    wr(`TRP_COUNT_ADDR, 8'hFE);
    wr(`TRP_RELOAD_ADDR, 8'hFE);
    wr(`TRP_DUTY_ADDR, 8'hFF);
    wr(`TRP_STATUS_ADDR, 8'h04);
    wr(`TRP_MODE_ADDR, 8'hF1);
    wait_ovf();
    chk(8'(overflow_o), 8'h01);
    chk(8'(overflow_irq_o), 8'h01);
    pwm_hi(8'h0A);
    wr(`TRP_DUTY_ADDR, 8'h10);
    pwm_hi(8'h00);
    wr(`TRP_MODE_ADDR, 8'h71);
    pwm_hi(8'h00);
    wr(`TRP_STATUS_ADDR, 8'h04);
    rchk(`TRP_STATUS_ADDR, 8'h04);
    chk(8'(overflow_irq_o), 8'h00);
    wr(`TRP_MODE_ADDR, 8'h70);
    chk(8'(pwm_pin_oe_o), 8'(gpio_oe_i));
    chk(8'(pwm_pin_o), 8'(gpio_out_i));
    // mid-interval reload write waits for the overflow; divide-by-128
    wr(`TRP_COUNT_ADDR, 8'hFE);
    wr(`TRP_RELOAD_ADDR, 8'hFE);
    wr(`TRP_MODE_ADDR, 8'h81);
    wr(`TRP_RELOAD_ADDR, 8'h80);
    wait_ovf();
    chk(8'(n > 120 && n < 262), 8'h01);
    rchk(`TRP_COUNT_ADDR, 8'h80);
    // oscillator enable every fourth clock paces the ticks, so the wrap comes later than at cpu rate
    wr(`TRP_MODE_ADDR, 8'h00);
    wr(`TRP_STATUS_ADDR, 8'h04);
    wr(`TRP_COUNT_ADDR, 8'hFE);
    wr(`TRP_RELOAD_ADDR, 8'hFE);
    wr(`TRP_MODE_ADDR, 8'hF4);
    wait_ovf();
    chk(8'(n > 4 && n < 10), 8'h01);
    // falling edges on the event pin as the timer clock
    wr(`TRP_MODE_ADDR, 8'h00);
    wr(`TRP_STATUS_ADDR, 8'h04);
    wr(`TRP_COUNT_ADDR, 8'hFD);
    wr(`TRP_RELOAD_ADDR, 8'hFD);
    wr(`TRP_MODE_ADDR, 8'h88);
    irq_pulse(8'h00);
    ev_pulse();
    ev_pulse();
    rchk(`TRP_COUNT_ADDR, 8'hFF);
    ev_pulse();
    chk(8'(overflow_o), 8'h01);
    rchk(`TRP_COUNT_ADDR, 8'hFD);
    wr(`TRP_MODE_ADDR, 8'h00);
    irq_pulse(8'h01);
    conclude();
  end
endmodule
